// *** hw/dpcm_pkg.sv ***
// Package of constants, types and arithmetic helpers for the speech codec
//
// Functional notes
// - Each timer selects plain timer mode or pulse-width modulator mode.
// - Modulator mode: free-running 8-bit up-counter compared with current sample.
// - Output high while counter below sample, low once counter reaches sample.
// - One modulation period is the counter stepping from lowest to highest count.
// - Prescaler zero clocks the counter every system clock: shortest period.
// - Prescaler two up to maximum slows the counter proportionally.
// - Every 8-bit sample is coded as one 4-bit difference code.
// - Encoder difference is sample minus predicted sample, not previous raw sample.
// - Prediction equals the most recent reconstructed sample.
// - Encoder difference is held as a 16-bit two's complement value.
// - Codes 0,8 give 0; 1-7 give -64..-1; 9-15 give 1..64.
// - Quantizer picks the nearest code set entry and emits its code.
// - Encoder uses fifteen levels; code 8 is never produced.
// - Nearest level found by binary search over fifteen levels.
// - Next prediction is previous prediction plus dequantized emitted code.
// - Prediction register holds its value for exactly one sample period.
// - Decoder dequantizes each code and adds it to its last prediction.
// - Input sample is the upper eight bits of the 10-bit converter word.
// - Encoder and decoder each handle one sample per 125 us period.
`default_nettype none

package dpcm_pkg;

   localparam int          ADC_W            = 10;
   localparam int          SAMPLE_W         = 8;
   localparam int          CODE_W           = 4;
   localparam int          DIFF_W           = 16;
   localparam int          ADC_DROP_BITS    = 2;
   localparam int          SAMPLE_PERIOD_NS = 125000;
   localparam int          CLK_PERIOD_NS    = 20;
   localparam int          SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          NUM_LEVELS       = 15;
   localparam int          SEARCH_STEPS     = 4;
   localparam logic [3:0]  ZERO_IDX         = 4'h7;
   localparam logic [3:0]  TOP_IDX          = 4'he;
   localparam logic [7:0]  PRED_RESET       = 8'h80;
   localparam logic [7:0]  SAMPLE_MAX       = 8'hff;
   localparam logic [7:0]  CNT_MAX          = 8'hff;

   typedef enum logic [1:0] {
      DPCM_ENC_IDLE   = 2'h0,
      DPCM_ENC_SEARCH = 2'h1,
      DPCM_ENC_EMIT   = 2'h3
   } dpcm_enc_state_t;

   // Code to signed difference
   function automatic logic signed [15:0] dpcm_dequant(input logic [3:0] code);
      case (code)
         4'h1:    dpcm_dequant = 16'hffc0;
         4'h2:    dpcm_dequant = 16'hffe0;
         4'h3:    dpcm_dequant = 16'hfff0;
         4'h4:    dpcm_dequant = 16'hfff8;
         4'h5:    dpcm_dequant = 16'hfffc;
         4'h6:    dpcm_dequant = 16'hfffe;
         4'h7:    dpcm_dequant = 16'hffff;
         4'h9:    dpcm_dequant = 16'h0001;
         4'ha:    dpcm_dequant = 16'h0002;
         4'hb:    dpcm_dequant = 16'h0004;
         4'hc:    dpcm_dequant = 16'h0008;
         4'hd:    dpcm_dequant = 16'h0010;
         4'he:    dpcm_dequant = 16'h0020;
         4'hf:    dpcm_dequant = 16'h0040;
         default: dpcm_dequant = 16'h0000;
      endcase
   endfunction

   // Sorted level index to code; code 8 never comes out
   function automatic logic [3:0] dpcm_idx_code(input logic [3:0] idx);
      dpcm_idx_code = (idx == ZERO_IDX) ? 4'h0 : 4'(idx + 4'h1);
   endfunction

   function automatic logic signed [15:0] dpcm_level(input logic [3:0] idx);
      dpcm_level = dpcm_dequant(dpcm_idx_code(idx));
   endfunction

   // Prediction plus difference, held in sample range
   function automatic logic [7:0] dpcm_add_clamp(input logic [7:0] pred,
                                                 input logic signed [15:0] d);
      logic signed [15:0] s;
      s = signed'({8'h00, pred}) + d;
      if (s < 16'sh0000)
         dpcm_add_clamp = 8'h00;
      else if (s > signed'({8'h00, SAMPLE_MAX}))
         dpcm_add_clamp = SAMPLE_MAX;
      else
         dpcm_add_clamp = s[7:0];
   endfunction

endpackage

`default_nettype wire

// *** hw/dpcm_pwm.sv ***
// Timer that runs either as a plain overflow timer or as a pulse-width modulator
`timescale 1ns/1ns
`default_nettype none

module dpcm_pwm (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic       pwm_mode_i,
   input  wire logic [7:0] prescale_i,
   input  wire logic [7:0] sample_i,
   output logic            pwm_o,
   output logic            wrap_o
);

   typedef struct packed {
      logic [7:0] cnt;
      logic [7:0] div;
      logic [7:0] hold;
      logic       pwm;
      logic       wrap;
   } dpcm_pwm_state_t;

   dpcm_pwm_state_t r;
   dpcm_pwm_state_t next_r;
   logic            adv;

   always_comb begin
      next_r      = r;
      next_r.wrap = 1'b0;
      adv         = 1'b0;
      // Prescale 0 or 1 steps every clock, else every prescale clocks
      if (prescale_i <= 8'h01) begin
         adv        = 1'b1;
         next_r.div = 8'h00;
      end else if (r.div >= 8'(prescale_i - 8'h01)) begin
         adv        = 1'b1;
         next_r.div = 8'h00;
      end else begin
         next_r.div = 8'(r.div + 8'h01);
      end
      if (adv) begin
         next_r.cnt = 8'(r.cnt + 8'h01);
         // New sample only at the period boundary, no runt pulses
         if (r.cnt == dpcm_pkg::CNT_MAX) begin
            next_r.hold = sample_i;
            next_r.wrap = 1'b1;
         end
      end
      // Strict less-than: equal gives low, zero sample stays low
      next_r.pwm = pwm_mode_i && (next_r.cnt < next_r.hold);
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign pwm_o  = r.pwm;
   assign wrap_o = r.wrap;

endmodule

`default_nettype wire

// *** hw/dpcm_decoder.sv ***
// DPCM decoder: rebuilds one sample from each received code
`timescale 1ns/1ns
`default_nettype none

module dpcm_decoder (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   input  wire logic [3:0] code_i,
   input  wire logic       code_valid_i,
   output logic [7:0]      sample_o,
   output logic            sample_valid_o
);

   typedef struct packed {
      logic [7:0] pred;
      logic       vld;
   } dpcm_dec_state_t;

   dpcm_dec_state_t r;
   dpcm_dec_state_t next_r;

   always_comb begin
      next_r     = r;
      next_r.vld = 1'b0;
      if (code_valid_i) begin
         next_r.pred = dpcm_pkg::dpcm_add_clamp(r.pred, dpcm_pkg::dpcm_dequant(code_i));
         next_r.vld  = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         r.pred <= dpcm_pkg::PRED_RESET;
         r.vld  <= 1'b0;
      end else begin
         r <= next_r;
      end
   end

   assign sample_o       = r.pred;
   assign sample_valid_o = r.vld;

endmodule

`default_nettype wire

// *** hw/dpcm_codec.sv ***
// Speech codec top: sample pacing, DPCM encoder, decoder feed and two timers
`timescale 1ns/1ns
`default_nettype none

module dpcm_codec #(
   parameter int SAMPLE_CYCLES = dpcm_pkg::SAMPLE_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // Converter side
   input  wire logic [9:0] adc_data_i,
   output logic            adc_start_o,
   // Encoded stream out
   output logic [3:0]      code_o,
   output logic            code_valid_o,
   output logic [7:0]      enc_recon_o,
   // Encoded stream in
   input  wire logic [3:0] rx_code_i,
   input  wire logic       rx_code_valid_i,
   output logic            rx_drop_o,
   output logic            rx_underrun_o,
   // Decoded samples
   output logic [7:0]      dec_sample_o,
   output logic            dec_valid_o,
   // Playback timers
   input  wire logic       play_mode_i,
   input  wire logic [7:0] play_prescale_i,
   input  wire logic       mon_mode_i,
   input  wire logic [7:0] mon_prescale_i,
   output logic            play_pwm_o,
   output logic            play_wrap_o,
   output logic            mon_pwm_o,
   output logic            mon_wrap_o
);

   localparam int CNT_W = $clog2(SAMPLE_CYCLES);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_CYCLES - 1);

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Twice the difference against the midpoint below a level index
   function automatic logic at_or_above(input logic signed [15:0] d,
                                        input logic [3:0] idx);
      logic signed [17:0] twice;
      logic signed [17:0] mid2;
      twice = 18'(d) <<< 1;
      mid2  = 18'(dpcm_pkg::dpcm_level(4'(idx - 4'h1)))
            + 18'(dpcm_pkg::dpcm_level(idx));
      at_or_above = (twice >= mid2);
   endfunction

   function automatic logic [3:0] mid_idx(input logic [3:0] lo,
                                          input logic [3:0] hi);
      logic [4:0] s;
      s       = 5'(lo) + 5'(hi) + 5'h01;
      mid_idx = s[4:1];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      dpcm_pkg::dpcm_enc_state_t st;
      logic [1:0]                step;
      logic [3:0]                lo;
      logic [3:0]                hi;
      logic signed [15:0]        diff;
      logic [7:0]                pred;
      logic [3:0]                code;
      logic                      code_vld;
      logic [CNT_W-1:0]          tick_cnt;
      logic                      tick;
      logic                      adc_start;
      logic [3:0]                rx_code;
      logic                      rx_pend;
      logic [3:0]                dec_code;
      logic                      dec_go;
      logic                      rx_drop;
      logic                      rx_under;
   } dpcm_top_state_t;

   dpcm_top_state_t r;
   dpcm_top_state_t next_r;
   logic [7:0]      in_sample;
   logic [3:0]      mid;
   logic [7:0]      dec_sample;
   logic            dec_valid;

   assign in_sample = adc_data_i[dpcm_pkg::ADC_W-1:dpcm_pkg::ADC_DROP_BITS];
   assign mid       = mid_idx(r.lo, r.hi);

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   always_comb begin
      next_r           = r;
      next_r.tick      = 1'b0;
      next_r.adc_start = 1'b0;
      next_r.code_vld  = 1'b0;
      next_r.dec_go    = 1'b0;
      next_r.rx_drop   = 1'b0;
      next_r.rx_under  = 1'b0;

      // Sample period pacing
      if (r.tick_cnt == CNT_LAST) begin
         next_r.tick_cnt = '0;
         next_r.tick     = 1'b1;
      end else begin
         next_r.tick_cnt = CNT_W'(r.tick_cnt + 1'b1);
      end
      // Converter restarts at each period so a fresh word waits next tick
      next_r.adc_start = r.tick;

      // Encoder
      case (r.st)
         dpcm_pkg::DPCM_ENC_IDLE: begin
            if (r.tick) begin
               // Against prediction, not against the last raw sample
               next_r.diff = signed'(16'(in_sample)) - signed'(16'(r.pred));
               next_r.lo   = 4'h0;
               next_r.hi   = dpcm_pkg::TOP_IDX;
               next_r.step = 2'h0;
               next_r.st   = dpcm_pkg::DPCM_ENC_SEARCH;
            end
         end
         dpcm_pkg::DPCM_ENC_SEARCH: begin
            // One tree level per clock, four levels cover fifteen entries
            if (at_or_above(r.diff, mid)) begin
               next_r.lo = mid;
            end else begin
               next_r.hi = 4'(mid - 4'h1);
            end
            next_r.step = 2'(r.step + 2'h1);
            if (r.step == 2'(dpcm_pkg::SEARCH_STEPS - 1)) begin
               next_r.st = dpcm_pkg::DPCM_ENC_EMIT;
            end
         end
         dpcm_pkg::DPCM_ENC_EMIT: begin
            next_r.code     = dpcm_pkg::dpcm_idx_code(r.lo);
            next_r.code_vld = 1'b1;
            // Held until the next emit: one sample period
            next_r.pred     = dpcm_pkg::dpcm_add_clamp(r.pred, dpcm_pkg::dpcm_level(r.lo));
            next_r.st       = dpcm_pkg::DPCM_ENC_IDLE;
         end
         default: begin
            next_r.st = dpcm_pkg::DPCM_ENC_IDLE;
         end
      endcase

      // Received codes wait for the period tick, one per period
      if (r.tick) begin
         if (r.rx_pend) begin
            next_r.dec_code = r.rx_code;
            next_r.dec_go   = 1'b1;
            next_r.rx_pend  = 1'b0;
         end else begin
            next_r.rx_under = 1'b1;
         end
      end
      // New arrival wins over consumption in the same cycle
      if (rx_code_valid_i) begin
         if (r.rx_pend && !r.tick) begin
            next_r.rx_drop = 1'b1;
         end
         next_r.rx_code = rx_code_i;
         next_r.rx_pend = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         r      <= '0;
         r.st   <= dpcm_pkg::DPCM_ENC_IDLE;
         r.pred <= dpcm_pkg::PRED_RESET;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Decoder and playback

   dpcm_decoder u_decoder (
      .clk_i          (clk_i),
      .reset_i        (reset_i),
      .code_i         (r.dec_code),
      .code_valid_i   (r.dec_go),
      .sample_o       (dec_sample),
      .sample_valid_o (dec_valid)
   );

   // Received speech to the reconstruction filter
   dpcm_pwm u_play (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .pwm_mode_i (play_mode_i),
      .prescale_i (play_prescale_i),
      .sample_i   (dec_sample),
      .pwm_o      (play_pwm_o),
      .wrap_o     (play_wrap_o)
   );

   // Second timer monitors the local encoder reconstruction
   dpcm_pwm u_mon (
      .clk_i      (clk_i),
      .reset_i    (reset_i),
      .pwm_mode_i (mon_mode_i),
      .prescale_i (mon_prescale_i),
      .sample_i   (r.pred),
      .pwm_o      (mon_pwm_o),
      .wrap_o     (mon_wrap_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs

   assign adc_start_o   = r.adc_start;
   assign code_o        = r.code;
   assign code_valid_o  = r.code_vld;
   assign enc_recon_o   = r.pred;
   assign rx_drop_o     = r.rx_drop;
   assign rx_underrun_o = r.rx_under;
   assign dec_sample_o  = dec_sample;
   assign dec_valid_o   = dec_valid;

endmodule

`default_nettype wire

// *** verif/dpcm_codec_asserts.sv ***
// Port checks for the speech codec top
`timescale 1ns/1ns
`default_nettype none

module dpcm_codec_asserts #(
   parameter int SAMPLE_CYCLES = 16
) (
   input wire logic       clk_i,
   input wire logic       reset_i,
   input wire logic       adc_start_o,
   input wire logic [3:0] code_o,
   input wire logic       code_valid_o,
   input wire logic [7:0] enc_recon_o,
   input wire logic       dec_valid_o,
   input wire logic       play_mode_i,
   input wire logic [7:0] play_prescale_i,
   input wire logic       play_pwm_o,
   input wire logic       play_wrap_o
);
   typedef struct packed {
      logic [15:0] scnt;
      logic        sok;
      logic [15:0] wcnt;
      logic        wok;
      logic [7:0]  ps;
   } dpcm_chk_t;

   dpcm_chk_t   st;
   dpcm_chk_t   next_st;
   logic [15:0] wlen;

   // Wrap spacing expected for the divider held over the period
   assign wlen = (st.ps < 8'h02) ? 16'h00ff : 16'({st.ps, 8'h00} - 16'h0001);

   always_comb begin
      next_st      = st;
      next_st.scnt = adc_start_o ? 16'h0000 : st.scnt + 16'h0001;
      next_st.sok  = st.sok | adc_start_o;
      next_st.wcnt = play_wrap_o ? 16'h0000 : st.wcnt + 16'h0001;
      next_st.wok  = play_wrap_o | (st.wok & (play_prescale_i == st.ps));
      next_st.ps   = play_prescale_i;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i)
         st <= '0;
      else
         st <= next_st;
   end

   default clocking dpcm_cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   a_start_code: assert property (adc_start_o |=> !code_valid_o [*4] ##1 code_valid_o)
      else $error("code not five cycles after converter start");
   a_sample_rate: assert property (adc_start_o && st.sok |-> st.scnt == 16'(SAMPLE_CYCLES - 1))
      else $error("sample period wrong");
   a_no_code_8: assert property (code_valid_o |-> code_o != 4'h8)
      else $error("unused zero code emitted");
   a_code_hold: assert property (!code_valid_o |-> $stable(code_o) && $stable(enc_recon_o))
      else $error("code or prediction moved between samples");
   a_zero_hold: assert property (code_valid_o && code_o == 4'h0 |-> enc_recon_o == $past(enc_recon_o))
      else $error("zero code changed prediction");
   a_step_up: assert property (code_valid_o && code_o == 4'hf |->
         enc_recon_o == (($past(enc_recon_o) > 8'hbf) ? 8'hff : $past(enc_recon_o) + 8'h40))
      else $error("largest step wrong");
   a_dec_tick: assert property (dec_valid_o |-> $past(adc_start_o))
      else $error("decoded sample off the sample tick");
   a_mode_low: assert property (!play_mode_i && !$past(play_mode_i) |-> !play_pwm_o)
      else $error("modulator output high in timer mode");
   a_wrap_len: assert property (play_wrap_o && st.wok |-> st.wcnt == wlen)
      else $error("carrier period wrong");
endmodule

`default_nettype wire

// *** verif/dpcm_filter_model.sv ***
// Converter source and playback filter model for the speech codec
`timescale 1ns/1ns
`default_nettype none

module dpcm_filter_model (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic [7:0]  word_i,
   input  wire logic        adc_start_i,
   output logic      [9:0]  adc_data_o,
   input  wire logic        pwm_i,
   input  wire logic        wrap_i,
   output logic      [15:0] duty_o,
   output logic      [15:0] period_o,
   output logic      [7:0]  n_o
);
   logic [15:0] acc;
   logic [15:0] len;

   // New result once a conversion starts; low bits are noise
   initial adc_data_o = 10'h200;
   always @(negedge clk_i) begin
      if (adc_start_i)
         adc_data_o <= {word_i, 2'($urandom)};
   end

   // High time and length of each carrier period
   always @(posedge clk_i) begin
      if (reset_i || wrap_i) begin
         acc <= 16'(pwm_i);
         len <= 16'h0001;
      end else begin
         acc <= acc + 16'(pwm_i);
         len <= len + 16'h0001;
      end
      if (reset_i)
         n_o <= 8'h00;
      else if (wrap_i) begin
         duty_o   <= acc;
         period_o <= len;
         n_o      <= n_o + 8'h01;
      end
   end
endmodule

`default_nettype wire

// *** verif/test_dpcm_codec.sv ***
// Self-checking bench for the speech codec top
`timescale 1ns/1ns
`default_nettype none

module test_dpcm_codec;
   logic             clk;
   logic             reset;
   logic [7:0]       word;
   logic [3:0]       rx_code;
   logic             rx_valid;
   logic             play_mode;
   logic [7:0]       play_ps;
   logic             mon_mode;
   logic [7:0]       mon_ps;
   wire logic [9:0]  adc_data;
   wire logic        adc_start, code_valid, drop, under, dec_valid, play_pwm, play_wrap, mon_pwm, mon_wrap;
   wire logic [3:0]  code;
   wire logic [7:0]  recon, dec, pn, mn;
   wire logic [15:0] pd, pp, md, mp;
   int               n_errors, cmp_count, ep, dp, dcode, exp_drop, exp_under, n_drop, n_under;
   bit               pend;
   logic [11:0]      enc_q[$];
   logic [7:0]       dec_q[$];
   int               lv[16] = '{0, -64, -32, -16, -8, -4, -2, -1, 0, 1, 2, 4, 8, 16, 32, 64};

   dpcm_codec #(.SAMPLE_CYCLES(16)) i_dut (
      .clk_i(clk), .reset_i(reset), .adc_data_i(adc_data), .adc_start_o(adc_start), .code_o(code),
      .code_valid_o(code_valid), .enc_recon_o(recon), .rx_code_i(rx_code), .rx_code_valid_i(rx_valid),
      .rx_drop_o(drop), .rx_underrun_o(under), .dec_sample_o(dec), .dec_valid_o(dec_valid),
      .play_mode_i(play_mode), .play_prescale_i(play_ps), .mon_mode_i(mon_mode), .mon_prescale_i(mon_ps),
      .play_pwm_o(play_pwm), .play_wrap_o(play_wrap), .mon_pwm_o(mon_pwm), .mon_wrap_o(mon_wrap));
   dpcm_filter_model p_play (.clk_i(clk), .reset_i(reset), .word_i(word), .adc_start_i(adc_start),
      .adc_data_o(adc_data), .pwm_i(play_pwm), .wrap_i(play_wrap), .duty_o(pd), .period_o(pp), .n_o(pn));
   dpcm_filter_model p_mon (.clk_i(clk), .reset_i(reset), .word_i(word), .adc_start_i(adc_start),
      .adc_data_o(), .pwm_i(mon_pwm), .wrap_i(mon_wrap), .duty_o(md), .period_o(mp), .n_o(mn));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic int quant(input int d);
      int b;
      b = 0;
      for (int c = 1; c < 16; c++)
         if (c != 8 && ((d - lv[c]) ** 2 < (d - lv[b]) ** 2 || ((d - lv[c]) ** 2 == (d - lv[b]) ** 2 && lv[c] > lv[b])))
            b = c;
      return b;
   endfunction

   function automatic int sat(input int v);
      return (v < 0) ? 0 : ((v > 255) ? 255 : v);
   endfunction

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("compares %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Next converter start; notes whether a code was pending for its tick
   task automatic wait_start();
      int k;
      k = 0;
      do begin
         @(negedge clk);
         k++;
      end while (adc_start !== 1'b1 && k < 40);
      if (k >= 40) begin
         n_errors++;
         stop_test();
      end
      if (!pend)
         exp_under++;
      pend = 0;
   endtask

   task automatic wait_wraps();
      logic [7:0] n0;
      int         k;
      n0 = mn;
      k = 0;
      while (8'(mn - n0) < 8'h03 && k < 200) begin
         wait_start();
         k++;
      end
      if (k >= 200) begin
         n_errors++;
         stop_test();
      end
   endtask

   task automatic send(input logic [3:0] c, input bit keep);
      rx_code = c;
      rx_valid = 1'b1;
      @(negedge clk);
      rx_valid = 1'b0;
      if (keep) begin
         dp = sat(dp + lv[c]);
         dec_q.push_back(8'(dp));
         pend = 1;
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge clk) begin
      if (!reset) begin
         if (adc_start === 1'b1) begin
            dcode = quant(int'(adc_data[9:2]) - ep);
            ep = sat(ep + lv[dcode]);
            enc_q.push_back({4'(dcode), 8'(ep)});
         end
         if (code_valid === 1'b1)
            check({4'h0, code, recon}, {4'h0, enc_q.pop_front()});
         if (dec_valid === 1'b1)
            check({8'h00, dec}, {8'h00, dec_q.pop_front()});
         n_drop += int'(drop === 1'b1);
         n_under += int'(under === 1'b1);
      end
   end

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   initial begin
      reset = 1'b1;
      word = 8'h80;
      rx_code = 4'h0;
      rx_valid = 1'b0;
      play_mode = 1'b0;
      play_ps = 8'h00;
      mon_mode = 1'b1;
      mon_ps = 8'h02;
      ep = 128;
      dp = 128;
      void'($urandom(85));
      repeat (5) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      check({4'h0, code, recon}, 16'h0080);
      check({8'h00, dec}, 16'h0080);
      $display("test reset done");
      for (int i = 0; i < 60; i++) begin
         wait_start();
         case ($urandom % 4)
            0: ;
            1: begin
               send(4'($urandom), 1'b0);
               @(negedge clk);
               send(4'($urandom), 1'b1);
               exp_drop++;
            end
            default: send(4'($urandom), 1'b1);
         endcase
         @(negedge clk);
         word = (i < 30) ? 8'($urandom) : ((i < 45) ? 8'h00 : 8'hff);
      end
      $display("test stream done");
      word = 8'h5a;
      play_mode = 1'b1;
      wait_wraps();
      check(pd, 16'(dp));
      check(pp, 16'h0100);
      check(md, 16'h00b4);
      check(mp, 16'h0200);
      $display("test playback done");
      play_mode = 1'b0;
      wait_wraps();
      check(pd, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         wait_start();
         send(4'h1, 1'b1);
      end
      play_mode = 1'b1;
      wait_wraps();
      check(pd, 16'h0000);
      $display("test zero done");
      wait_start();
      repeat (4) @(negedge clk);
      check(16'(n_drop), 16'(exp_drop));
      check(16'(n_under), 16'(exp_under));
      stop_test();
   end
endmodule

bind dpcm_codec dpcm_codec_asserts #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_chk (
   .clk_i(clk_i), .reset_i(reset_i), .adc_start_o(adc_start_o), .code_o(code_o), .code_valid_o(code_valid_o),
   .enc_recon_o(enc_recon_o), .dec_valid_o(dec_valid_o), .play_mode_i(play_mode_i),
   .play_prescale_i(play_prescale_i), .play_pwm_o(play_pwm_o), .play_wrap_o(play_wrap_o));

`default_nettype wire
